// ===== core/mmb_defs.svh
// constants for the bus handover block
`ifndef MMB_DEFS_SVH
`define MMB_DEFS_SVH
`define MMB_CTRL_OFS 8'h00
`define MMB_STAT_OFS 8'h04
`define MMB_CTRL_RST 2'h3
`define MMB_CTRL_HI_BIT 0
`define MMB_CTRL_LO_BIT 1
`define MMB_ECHO_CYC 3'h3
`define MMB_Q_NONE 2'h0
`define MMB_Q_FIRST 2'h1
`define MMB_Q_EMPTY 2'h2
`define MMB_Q_NEXT 2'h3
`define MMB_RESP_OK 2'h0
`define MMB_RESP_ERR 2'h2
`endif

// ===== core/mmb_pkg.sv
// types for the bus handover block
package mmb_pkg;
  typedef enum logic [2:0] {
    mmb_bst_idle, mmb_bst_first, mmb_bst_second,
    mmb_bst_third, mmb_bst_fourth, mmb_bst_wait
  } mmb_bus_state_type;
  typedef enum logic [2:0] {
    mmb_arb_idle, mmb_arb_grant, mmb_arb_owned,
    mmb_arb_reclaim, mmb_arb_gap
  } mmb_arb_state_type;
  typedef struct packed {
    mmb_bus_state_type bus_state;
    logic cycle_pending;
    logic low_byte_of_word;
    logic first_interrupt_acknowledge_cycle;
    logic second_interrupt_acknowledge_cycle;
    logic lock_prefix;
    logic instr_done;
    logic queue_op_valid;
    logic [1:0] queue_op;
  } mmb_core_type;
  typedef struct packed {
    logic fetch_detach;
    logic resume_fourth;
    logic resume_first;
  } mmb_to_core_type;
endpackage

// ===== core/mmb_handover.sv
// maximum mode local bus handover, lock and queue status
`timescale 1ns/1ps
`include "mmb_defs.svh"
module mmb_handover
  import mmb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu core side
  input wire mmb_core_type core_in,
  output mmb_to_core_type core_out,
  // pins
  input wire logic config_strap,
  input wire logic request_grant_line_hi_prio_i,
  output logic request_grant_line_hi_prio_o,
  output logic request_grant_line_hi_prio_oe,
  input wire logic request_grant_line_lo_prio_i,
  output logic request_grant_line_lo_prio_o,
  output logic request_grant_line_lo_prio_oe,
  output logic lock_n_o,
  output logic lock_n_oe,
  output logic byte_high_o,
  output logic byte_high_oe,
  output logic [1:0] queue_state_bits
);

  // pin synchronisers: [0] hi, [1] lo, [2] strap
  logic [2:0] sync1_ff, sync2_ff, prev_ff;
  logic [2:0] nxt_sync1, nxt_sync2, nxt_prev;
  logic [1:0] fall;

  always_comb begin
    nxt_sync1 = {config_strap, request_grant_line_lo_prio_i,
                 request_grant_line_hi_prio_i};
    nxt_sync2 = sync1_ff;
    nxt_prev = sync2_ff;
    if (!reset_n) begin
      nxt_sync1 = 3'h7;
      nxt_sync2 = 3'h7;
      nxt_prev = 3'h7;
    end
  end

  always_ff @(posedge clk) begin
    sync1_ff <= nxt_sync1;
    sync2_ff <= nxt_sync2;
    prev_ff <= nxt_prev;
  end

  // one-clock low pulse seen as a falling edge
  assign fall = prev_ff[1:0] & ~sync2_ff[1:0];

  logic max_mode;
  assign max_mode = ~sync2_ff[2];

  // register file
  logic [1:0] ctrl_ff, nxt_ctrl;

  // arbiter state
  mmb_arb_state_type arb_ff, nxt_arb;
  logic owner_ff, nxt_owner;
  logic [1:0] pend_ff, nxt_pend;
  logic early_ff, nxt_early;
  logic [2:0] echo_ff, nxt_echo;
  logic lock_ff, nxt_lock;
  logic lock_wait_ff, nxt_lock_wait;
  logic [1:0] qs_ff, nxt_qs;
  logic ok_conds, grant_ok, sel, granted;
  logic [1:0] line_live;
  mmb_bus_state_type bst;

  assign bst = core_in.bus_state;
  assign granted = (arb_ff == mmb_arb_grant) ||
                   (arb_ff == mmb_arb_owned);

  always_comb begin
    ok_conds = !core_in.low_byte_of_word && !core_in.first_interrupt_acknowledge_cycle &&
               !lock_ff;
    grant_ok = 1'b0;
    if (max_mode && ok_conds) begin
      if (bst == mmb_bst_idle) begin
        grant_ok = 1'b1;
      end else if (early_ff && bst == mmb_bst_fourth) begin
        // decided in fourth so the pulse lands in the first clock
        grant_ok = 1'b1;
      end
    end
    sel = !pend_ff[0];
  end

  always_comb begin
    nxt_arb = arb_ff;
    nxt_owner = owner_ff;
    nxt_pend = pend_ff;
    nxt_early = early_ff;
    nxt_echo = echo_ff;
    line_live[0] = !(granted && owner_ff == 1'b0) &&
                   ctrl_ff[`MMB_CTRL_HI_BIT];
    line_live[1] = !(granted && owner_ff == 1'b1) &&
                   ctrl_ff[`MMB_CTRL_LO_BIT];
    unique case (arb_ff)
      mmb_arb_idle: begin
        if (|pend_ff && grant_ok) begin
          nxt_arb = mmb_arb_grant;
          nxt_owner = sel;
          nxt_pend[sel] = 1'b0;
          nxt_early = 1'b0;
        end
      end
      mmb_arb_grant: begin
        nxt_arb = mmb_arb_owned;
        nxt_echo = `MMB_ECHO_CYC;
      end
      mmb_arb_owned: begin
        if (echo_ff != 3'h0) begin
          nxt_echo = echo_ff - 3'h1;
        end else if (fall[owner_ff]) begin
          nxt_arb = mmb_arb_reclaim;
        end
      end
      mmb_arb_reclaim: begin
        nxt_arb = mmb_arb_gap;
      end
      mmb_arb_gap: begin
        nxt_arb = mmb_arb_idle;
      end
    endcase
    // other line heard in any state; a new request beats the grant clear
    if (|(fall & line_live)) begin
      nxt_pend = nxt_pend | (fall & line_live);
      if (bst == mmb_bst_idle || bst == mmb_bst_first ||
          bst == mmb_bst_second) begin
        nxt_early = 1'b1;
      end
    end
    if (!reset_n) begin
      nxt_arb = mmb_arb_idle;
      nxt_owner = 1'b0;
      nxt_pend = 2'h0;
      nxt_early = 1'b0;
      nxt_echo = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    arb_ff <= nxt_arb;
    owner_ff <= nxt_owner;
    pend_ff <= nxt_pend;
    early_ff <= nxt_early;
    echo_ff <= nxt_echo;
  end

  // lock tracking
  always_comb begin
    nxt_lock = lock_ff;
    nxt_lock_wait = lock_wait_ff;
    if (core_in.lock_prefix) begin
      nxt_lock = 1'b1;
      nxt_lock_wait = 1'b1;
    end else if (lock_wait_ff && core_in.instr_done) begin
      nxt_lock = 1'b0;
      nxt_lock_wait = 1'b0;
    end
    if (max_mode && bst == mmb_bst_second) begin
      if (core_in.first_interrupt_acknowledge_cycle) begin
        nxt_lock = 1'b1;
      end else if (core_in.second_interrupt_acknowledge_cycle && !lock_wait_ff) begin
        nxt_lock = 1'b0;
      end
    end
    if (!reset_n) begin
      nxt_lock = 1'b0;
      nxt_lock_wait = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    lock_ff <= nxt_lock;
    lock_wait_ff <= nxt_lock_wait;
  end

  // queue status, one clock after the operation
  always_comb begin
    nxt_qs = `MMB_Q_NONE;
    if (core_in.queue_op_valid) begin
      nxt_qs = core_in.queue_op;
    end
    if (!reset_n) begin
      nxt_qs = `MMB_Q_NONE;
    end
  end

  always_ff @(posedge clk) begin
    qs_ff <= nxt_qs;
  end

  assign queue_state_bits = qs_ff;

  // pin drive
  always_comb begin
    request_grant_line_hi_prio_o = 1'b0;
    request_grant_line_lo_prio_o = 1'b0;
    request_grant_line_hi_prio_oe = (arb_ff == mmb_arb_grant) &&
                                    !owner_ff;
    request_grant_line_lo_prio_oe = (arb_ff == mmb_arb_grant) &&
                                    owner_ff;
    lock_n_o = granted | ~lock_ff;
    lock_n_oe = max_mode && !granted;
    byte_high_o = 1'b1;
    byte_high_oe = !granted;
    core_out.fetch_detach = granted;
    core_out.resume_fourth = (arb_ff == mmb_arb_reclaim) &&
                             core_in.cycle_pending;
    core_out.resume_first = (arb_ff == mmb_arb_reclaim) &&
                            !core_in.cycle_pending;
  end

  // axi4-lite slave
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [1:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata[1:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (aw_got_ff && w_got_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `MMB_RESP_OK;
      if (awaddr_ff[7:2] == 6'(`MMB_CTRL_OFS >> 2)) begin
        if (wstrb0_ff) begin
          nxt_ctrl = wdata_ff;
        end
      end else if (awaddr_ff[7:2] != 6'(`MMB_STAT_OFS >> 2)) begin
        nxt_bresp = `MMB_RESP_ERR;
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (!reset_n) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_awaddr = 8'h00;
      nxt_wdata = 2'h0;
      nxt_wstrb0 = 1'b0;
      nxt_bvalid = 1'b0;
      nxt_bresp = `MMB_RESP_OK;
      nxt_ctrl = `MMB_CTRL_RST;
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `MMB_RESP_OK;
      nxt_rdata = 32'h0000_0000;
      if (s_axi_araddr[7:2] == 6'(`MMB_CTRL_OFS >> 2)) begin
        nxt_rdata[1:0] = ctrl_ff;
      end else if (s_axi_araddr[7:2] == 6'(`MMB_STAT_OFS >> 2)) begin
        nxt_rdata[2:0] = arb_ff;
        nxt_rdata[3] = owner_ff;
        nxt_rdata[5:4] = pend_ff;
        nxt_rdata[6] = lock_ff;
        nxt_rdata[7] = max_mode;
        nxt_rdata[9:8] = qs_ff;
      end else begin
        nxt_rresp = `MMB_RESP_ERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (!reset_n) begin
      nxt_rvalid = 1'b0;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = `MMB_RESP_OK;
    end
  end

  always_ff @(posedge clk) begin
    aw_got_ff <= nxt_aw_got;
    w_got_ff <= nxt_w_got;
    awaddr_ff <= nxt_awaddr;
    wdata_ff <= nxt_wdata;
    wstrb0_ff <= nxt_wstrb0;
    bvalid_ff <= nxt_bvalid;
    bresp_ff <= nxt_bresp;
    ctrl_ff <= nxt_ctrl;
    rvalid_ff <= nxt_rvalid;
    rdata_ff <= nxt_rdata;
    rresp_ff <= nxt_rresp;
  end

endmodule

// ===== verification/mmb_handover_properties.sv
// timing checks on the bus handover block ports
`timescale 1ns/1ps
module mmb_handover_properties
  import mmb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // core side
  input wire mmb_core_type core_in,
  input wire mmb_to_core_type core_out,
  // pins
  input wire logic request_grant_line_hi_prio_o,
  input wire logic request_grant_line_hi_prio_oe,
  input wire logic request_grant_line_lo_prio_o,
  input wire logic request_grant_line_lo_prio_oe,
  input wire logic lock_n_o,
  input wire logic lock_n_oe,
  input wire logic byte_high_o,
  input wire logic byte_high_oe,
  input wire logic [1:0] queue_state_bits
);
  logic hi_g, lo_g, gnt, det, rsm;
  assign hi_g = request_grant_line_hi_prio_oe;
  assign lo_g = request_grant_line_lo_prio_oe;
  assign gnt = hi_g | lo_g;
  assign det = core_out.fetch_detach;
  assign rsm = core_out.resume_first | core_out.resume_fourth;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_grant_one_clock: assert property (gnt |=> !gnt)
    else $error("grant longer than one clock");
  a_grant_in_slot: assert property (gnt |-> core_in.bus_state inside
    {mmb_bst_first, mmb_bst_fourth, mmb_bst_idle})
    else $error("grant outside allowed bus clock");
  a_grant_detaches: assert property (gnt |-> det)
    else $error("fetch unit attached during grant");
  a_grant_single_line: assert property (!(hi_g && lo_g))
    else $error("grant on both lines");
  a_grant_low: assert property (hi_g |-> !request_grant_line_hi_prio_o)
    else $error("grant pulse not low");
  a_grant_low_lo: assert property (lo_g |-> !request_grant_line_lo_prio_o)
    else $error("low priority grant pulse not low");
  a_lock_floats: assert property (det |-> !lock_n_oe && lock_n_o)
    else $error("lock driven while granted");
  a_lock_prefix: assert property (core_in.lock_prefix &&
    !core_in.instr_done && !det |=> !lock_n_o || det)
    else $error("lock not asserted after prefix");
  a_queue_code: assert property (core_in.queue_op_valid |=>
    queue_state_bits == $past(core_in.queue_op))
    else $error("queue code not shown next clock");
  a_queue_idle: assert property (!core_in.queue_op_valid |=>
    queue_state_bits == 2'h0)
    else $error("queue code without operation");
  a_byte_high: assert property (byte_high_o && byte_high_oe == !det)
    else $error("byte high pin wrong");
  a_resume_pulse: assert property (rsm |=> !rsm)
    else $error("resume pulse too long");
  c_grant_hi: cover property (hi_g);
  c_grant_lo: cover property (lo_g);
  c_resume_fourth: cover property (core_out.resume_fourth);
endmodule

// ===== verification/mmb_requester.sv
// another local bus master on one request/grant line
`timescale 1ns/1ps
module mmb_requester (
  // clock and line
  input wire logic clk,
  input wire logic line,
  // bench control
  input wire logic start,
  input wire logic [3:0] hold,
  // pull line low, ownership
  output logic drv,
  output logic own
);
  logic [2:0] st;
  logic [3:0] cnt;
  initial begin
    st = 3'h0;
    drv = 1'b0;
    cnt = 4'h0;
  end
  assign own = (st == 3'h3);
  // sampled on the rising edge, pulses one clock low
  always @(posedge clk) begin
    drv <= 1'b0;
    case (st)
      3'h0: if (start) begin
        drv <= 1'b1;
        st <= 3'h1;
      end
      3'h1: st <= 3'h2;
      3'h2: if (!line) begin
        st <= 3'h3;
        cnt <= hold;
      end
      3'h3: if (cnt == 4'h0) begin
        drv <= 1'b1;
        st <= 3'h4;
      end else cnt <= cnt - 4'h1;
      default: st <= 3'h0;
    endcase
  end
endmodule

// ===== verification/tb.sv
// self-checking bench for the bus handover block
`timescale 1ns/1ps
module tb;
  import mmb_pkg::*;
  logic clk, reset_n, config_strap;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, hold;
  logic [1:0] s_axi_bresp, s_axi_rresp, queue_state_bits;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  mmb_core_type core_in;
  mmb_to_core_type core_out;
  logic request_grant_line_hi_prio_i, request_grant_line_hi_prio_o;
  logic request_grant_line_hi_prio_oe, request_grant_line_lo_prio_i;
  logic request_grant_line_lo_prio_o, request_grant_line_lo_prio_oe;
  logic lock_n_o, lock_n_oe, byte_high_o, byte_high_oe;
  logic [1:0] start, drv, own;
  int fail_count, n_tests, seed, k, nf, n4;
  // bus hold keeps released lines high
  assign request_grant_line_hi_prio_i = !(drv[0] ||
    request_grant_line_hi_prio_oe && !request_grant_line_hi_prio_o);
  assign request_grant_line_lo_prio_i = !(drv[1] ||
    request_grant_line_lo_prio_oe && !request_grant_line_lo_prio_o);
  mmb_handover u_mmb_handover (.*);
  mmb_requester u_mmb_requester_hi (.clk(clk),
    .line(request_grant_line_hi_prio_i), .start(start[0]),
    .hold(hold), .drv(drv[0]), .own(own[0]));
  mmb_requester u_mmb_requester_lo (.clk(clk),
    .line(request_grant_line_lo_prio_i), .start(start[1]),
    .hold(hold), .drv(drv[1]), .own(own[1]));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
    return {30'h0, v[1:0]};
  endfunction
  task conclude;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task guard;
    if (k > 80) begin
      fail_count++;
      conclude();
    end
  endtask
  task ax(input logic w, input logic [7:0] a, input logic [31:0] v,
          input logic [1:0] r);
    logic [2:0] p;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    p = {1'b1, w, 1'b1};
    for (k = 0; p != 3'h0; k++) begin
      @(posedge clk);
      guard();
      if (p[0] && (w ? s_axi_awready : s_axi_arready)) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        p[0] = 1'b0;
      end
      if (p[1] && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        p[1] = 1'b0;
      end
      if (p[2] && (w ? s_axi_bvalid : s_axi_rvalid)) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        p[2] = 1'b0;
        chk(w ? s_axi_bresp : s_axi_rresp, r);
        if (!w && r == 2'h0) chk(s_axi_rdata, v);
      end
    end
  endtask
  task wait_own(input int w);
    for (k = 0; own[w] !== 1'b1; k++) begin
      @(posedge clk);
      guard();
    end
  endtask
  task xchg(input int w, input logic p);
    @(posedge clk);
    core_in.cycle_pending <= p;
    hold <= 4'h3 | 4'($random(seed));
    start[w] <= 1'b1;
    @(posedge clk);
    start[w] <= 1'b0;
    wait_own(w);
    chk(core_out.fetch_detach, 1'b1);
    chk(lock_n_oe, 1'b0);
    nf = 0;
    n4 = 0;
    repeat (40) begin
      @(negedge clk);
      nf += core_out.resume_first;
      n4 += core_out.resume_fourth;
    end
    chk(nf, !p);
    chk(n4, p);
  endtask
  task interrupt_acknowledge_cycle(input logic f, input logic e);
    @(posedge clk);
    core_in.bus_state <= mmb_bst_second;
    core_in.first_interrupt_acknowledge_cycle <= f;
    core_in.second_interrupt_acknowledge_cycle <= !f;
    @(posedge clk);
    core_in.bus_state <= mmb_bst_third;
    repeat (2) @(negedge clk);
    chk(lock_n_o, e);
    @(posedge clk);
    core_in <= '0;
  endtask
  task pulse_core(input int which);
    @(posedge clk);
    if (which == 0) core_in.lock_prefix <= 1'b1;
    else core_in.instr_done <= 1'b1;
    @(posedge clk);
    core_in <= '0;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    seed = 32'hf0cc67b6;
    fail_count = 0;
    n_tests = 0;
    reset_n = 1'b0;
    config_strap = 1'b0;
    core_in = '0;
    start = 2'h0;
    hold = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    ax(1'b0, 8'h00, 32'h3, 2'h0);
    d = $random(seed);
    ax(1'b1, 8'h00, d, 2'h0);
    ax(1'b0, 8'h00, exp_ctrl(d), 2'h0);
    ax(1'b1, 8'h0c, d, 2'h2);
    ax(1'b0, 8'h10, 32'h0, 2'h2);
    s_axi_wstrb <= 4'he;
    ax(1'b1, 8'h00, 32'h0, 2'h0);
    ax(1'b0, 8'h00, exp_ctrl(d), 2'h0);
    s_axi_wstrb <= 4'hf;
    ax(1'b1, 8'h04, 32'h0, 2'h0);
    ax(1'b0, 8'h04, 32'h80, 2'h0);
    ax(1'b1, 8'h00, 32'h3, 2'h0);
    for (int i = 0; i < 8; i++) begin
      d = (i < 4) ? i : $random(seed);
      @(posedge clk);
      core_in.queue_op_valid <= 1'b1;
      core_in.queue_op <= d[1:0];
      @(posedge clk);
      core_in.queue_op_valid <= 1'b0;
      @(negedge clk);
      chk(queue_state_bits, d[1:0]);
      @(negedge clk);
      chk(queue_state_bits, 2'h0);
    end
    xchg(0, 1'b0);
    xchg(0, 1'b1);
    xchg(1, 1'b0);
    @(posedge clk);
    start <= 2'h3;
    @(posedge clk);
    start <= 2'h0;
    wait_own(0);
    chk(own[1], 1'b0);
    wait_own(1);
    repeat (40) @(posedge clk);
    start[0] <= 1'b1;
    @(posedge clk);
    start[0] <= 1'b0;
    wait_own(0);
    start[1] <= 1'b1;
    @(posedge clk);
    start[1] <= 1'b0;
    wait_own(1);
    chk(own[0], 1'b0);
    repeat (40) @(posedge clk);
    pulse_core(0);
    chk(lock_n_o, 1'b0);
    pulse_core(1);
    chk(lock_n_o, 1'b1);
    interrupt_acknowledge_cycle(1'b1, 1'b0);
    interrupt_acknowledge_cycle(1'b0, 1'b1);
    ax(1'b1, 8'h00, 32'h1, 2'h0);
    @(posedge clk);
    start[1] <= 1'b1;
    @(posedge clk);
    start[1] <= 1'b0;
    repeat (30) @(posedge clk);
    chk(own[1], 1'b0);
    config_strap <= 1'b1;
    repeat (4) @(posedge clk);
    start[0] <= 1'b1;
    @(posedge clk);
    start[0] <= 1'b0;
    repeat (30) @(posedge clk);
    chk(own[0], 1'b0);
    chk(lock_n_oe, 1'b0);
    conclude();
  end
endmodule
bind mmb_handover mmb_handover_properties u_mmb_handover_properties (.*);
